/* File: rtl/cal_gate_pkg.sv */
// Constants for the calibration mode command gate
// What this block does
// R1 - Enter command switches into calibration mode
// R2 - Calibration action without jack is rejected
// R3 - Jack fitted, not calibrating: indicator blinks
// R4 - Calibrating: indicator steady, CAL word shown
// R5 - Sample, track, null refused while calibrating
// R6 - Entering calibration forces track to hold
// R7 - Entering calibration clears null, drops offsets
// R8 - Hi, lo, store accepted only while calibrating
// R9 - Calibrate only the selected function and range
// R10 - Return command leaves calibration mode
// R11 - Address from five switches, 0 to 30
// R12 - Hi and lo carry six digit counts
// R13 - Store computes constants, reports good or error
// R14 - Mode refusals change nothing, report error
package cal_gate_pkg;
  localparam int ADDR_W = 32;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
  localparam logic [11:0] OFS_CMD = 12'h010;
  localparam logic [11:0] OFS_ARG = 12'h014;
  localparam logic [11:0] OFS_HI = 12'h018;
  localparam logic [11:0] OFS_LO = 12'h01c;
  localparam logic [11:0] OFS_SEL = 12'h020;
  // Command codes written to the command register
  localparam logic [3:0] CMD_ENTER_CAL = 4'h1;
  localparam logic [3:0] CMD_LEAVE_CAL = 4'h2;
  localparam logic [3:0] CMD_SAMPLE = 4'h3;
  localparam logic [3:0] CMD_TRACK = 4'h4;
  localparam logic [3:0] CMD_NULL = 4'h5;
  localparam logic [3:0] CMD_HI_POINT = 4'h6;
  localparam logic [3:0] CMD_LO_POINT = 4'h7;
  localparam logic [3:0] CMD_STORE = 4'h8;
  // Error codes
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_NO_JACK = 4'h1;
  localparam logic [3:0] ERR_MODE = 4'h2;
  localparam logic [3:0] ERR_ARG = 4'h3;
  localparam logic [3:0] ERR_STORE = 4'h4;
  localparam logic [3:0] ERR_ADDR = 4'h5;
  // Interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_MODE = 2;
  localparam int IRQ_W = 3;
  localparam int ARG_MAX = 999999;
  localparam int ADDR_MAX = 30;
  localparam int BLINK_MS = 250;
  localparam int CLK_KHZ = 125000;
  localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
  localparam int FUNC_W = 3;
  localparam int RANGE_W = 3;
endpackage : cal_gate_pkg

/* File: rtl/cal_sync2.sv */
// Two flip-flop synchroniser for pin inputs
module cal_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Data
  input wire logic [W-1:0] async,
  output logic [W-1:0] sync
);
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  initial begin
    if (W < 1) $error("width must be positive");
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async;
      stage2_q <= stage1_q;
    end
  end
  assign sync = stage2_q;
endmodule : cal_sync2

/* File: rtl/cal_blinker.sv */
// Free running blink divider for the calibration indicator
module cal_blinker #(
  parameter int unsigned HALF = 31250000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Phase
  output logic phase
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic phase_q;
  wire wrap = (cnt_q >= HALF - 1);
  initial begin
    if (HALF < 1) $error("blink half period must be positive");
  end
  assign cnt_d = wrap ? 32'h0 : cnt_q + 32'h1;
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 32'h0;
      phase_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (wrap) phase_q <= ~phase_q;
    end
  end
  assign phase = phase_q;
endmodule : cal_blinker

/* File: rtl/cal_gate.sv */
// Calibration mode command gate with AHB-Lite register slave
module cal_gate #(
  parameter int unsigned BLINK_HALF = cal_gate_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Rear panel pins
  input wire logic jackPin,
  input wire logic [4:0] addrSwPin,
  input wire logic talkOnlyPin,
  input wire logic listenOnlyPin,
  // Measurement engine
  output logic sampleTrig,
  output logic pointStart,
  output logic pointIsHi,
  output logic [19:0] pointArg,
  output logic storeStart,
  input wire logic engineDone,
  input wire logic engineOk,
  input wire logic [19:0] measCount,
  // Settings and display
  output logic trackOn,
  output logic nullOn,
  output logic nullFlush,
  output logic [cal_gate_pkg::FUNC_W-1:0] funcSel,
  output logic [cal_gate_pkg::RANGE_W-1:0] rangeSel,
  output logic calLamp,
  output logic calWord,
  output logic goodWord,
  output logic [4:0] busAddr,
  output logic irq
);
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_CAL = 3'b010,
    ST_BUSY = 3'b100
  } mode_e;
  mode_e mode_q, mode_d;

  logic jackFit, talkOnly, listenOnly, blinkPhase;
  logic [4:0] addrSw;
  cal_sync2 #(.W(8)) u_sync (
    .clk(clk),
    .reset(reset),
    .async({jackPin, talkOnlyPin, listenOnlyPin, addrSwPin}),
    .sync({jackFit, talkOnly, listenOnly, addrSw})
  );
  cal_blinker #(.HALF(BLINK_HALF)) u_blink (
    .clk(clk),
    .reset(reset),
    .phase(blinkPhase)
  );

  // Bus address phase capture
  logic wrPend_q, rdPend_q;
  logic [11:0] ofs_q;
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      ofs_q <= 12'h0;
    end else begin
      wrPend_q <= take && hwrite;
      rdPend_q <= take && !hwrite;
      if (take) ofs_q <= haddr[11:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire wrCmd = wrPend_q && ofs_q == cal_gate_pkg::OFS_CMD;
  wire wrArg = wrPend_q && ofs_q == cal_gate_pkg::OFS_ARG;
  wire wrSel = wrPend_q && ofs_q == cal_gate_pkg::OFS_SEL;
  wire wrMask = wrPend_q && ofs_q == cal_gate_pkg::OFS_IRQ_MASK;
  wire wrCtrl = wrPend_q && ofs_q == cal_gate_pkg::OFS_CTRL;
  wire rdIrq = rdPend_q && ofs_q == cal_gate_pkg::OFS_IRQ_STAT;
  wire [3:0] cmd = hwdata[3:0];

  // Settings held by the block
  logic trackOn_q, nullOn_q, good_q, isHi_q;
  logic [19:0] arg_q, hiCnt_q, loCnt_q;
  logic [3:0] err_q, err_d;
  logic [cal_gate_pkg::FUNC_W-1:0] func_q;
  logic [cal_gate_pkg::RANGE_W-1:0] range_q;
  logic [3:0] irqStat_q, irqMask_q, irqEv;
  // Remembers whether the last engine request was a store
  logic storeBusy_q;

  wire inCal = mode_q != ST_NORMAL;
  wire idleCal = mode_q == ST_CAL;
  wire addrOk = addrSw <= 5'(cal_gate_pkg::ADDR_MAX); // R11
  wire argOk = arg_q <= 20'(cal_gate_pkg::ARG_MAX); // R12
  wire isCalCmd = cmd == cal_gate_pkg::CMD_ENTER_CAL ||
                  cmd == cal_gate_pkg::CMD_HI_POINT ||
                  cmd == cal_gate_pkg::CMD_LO_POINT ||
                  cmd == cal_gate_pkg::CMD_STORE;
  wire isNormCmd = cmd == cal_gate_pkg::CMD_SAMPLE ||
                   cmd == cal_gate_pkg::CMD_TRACK ||
                   cmd == cal_gate_pkg::CMD_NULL;
  wire isPoint = cmd == cal_gate_pkg::CMD_HI_POINT ||
                 cmd == cal_gate_pkg::CMD_LO_POINT;
  wire calBlocked = isCalCmd && (!jackFit || !addrOk ||
                    talkOnly || listenOnly); // R2 R11
  wire modeBad = (isNormCmd && inCal) || // R5
                 (isCalCmd && cmd != cal_gate_pkg::CMD_ENTER_CAL &&
                  !idleCal); // R8
  wire go = wrCmd && !calBlocked && !modeBad &&
            !(isPoint && !argOk);
  wire doEnter = go && cmd == cal_gate_pkg::CMD_ENTER_CAL && !inCal; // R1
  wire doLeave = go && cmd == cal_gate_pkg::CMD_LEAVE_CAL && idleCal; // R10
  wire doPoint = go && isPoint;
  wire doStore = go && cmd == cal_gate_pkg::CMD_STORE; // R13
  wire selLocked = inCal && !idleCal; // R9

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      ST_NORMAL: if (doEnter) mode_d = ST_CAL;
      ST_CAL: begin
        if (doLeave) mode_d = ST_NORMAL;
        else if (doPoint || doStore) mode_d = ST_BUSY;
      end
      ST_BUSY: if (engineDone) mode_d = ST_CAL;
      default: mode_d = ST_NORMAL;
    endcase
  end

  always_comb begin
    err_d = err_q;
    if (wrCmd) begin
      err_d = cal_gate_pkg::ERR_NONE;
      if (calBlocked && !jackFit) err_d = cal_gate_pkg::ERR_NO_JACK;
      else if (calBlocked) err_d = cal_gate_pkg::ERR_ADDR;
      else if (modeBad) err_d = cal_gate_pkg::ERR_MODE; // R14
      else if (isPoint && !argOk) err_d = cal_gate_pkg::ERR_ARG;
    end else if (mode_q == ST_BUSY && engineDone && !engineOk) begin
      err_d = cal_gate_pkg::ERR_STORE; // R13
    end
  end

  assign irqEv[cal_gate_pkg::IRQ_DONE] = mode_q == ST_BUSY && engineDone;
  assign irqEv[cal_gate_pkg::IRQ_ERR] = err_d != cal_gate_pkg::ERR_NONE &&
                                        err_d != err_q;
  assign irqEv[cal_gate_pkg::IRQ_MODE] = doEnter || doLeave;
  assign irqEv[3] = 1'b0;

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= ST_NORMAL;
      err_q <= cal_gate_pkg::ERR_NONE;
      irqStat_q <= 4'h0;
      irqMask_q <= 4'h0;
    end else begin
      mode_q <= mode_d;
      err_q <= err_d;
      // New events win over the read clear
      irqStat_q <= (rdIrq ? 4'h0 : irqStat_q) | irqEv;
      if (wrMask) irqMask_q <= hwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trackOn_q <= 1'b1;
      nullOn_q <= 1'b0;
      good_q <= 1'b0;
      isHi_q <= 1'b0;
      arg_q <= 20'h0;
      hiCnt_q <= 20'h0;
      loCnt_q <= 20'h0;
      func_q <= '0;
      range_q <= '0;
    end else begin
      if (doEnter) begin
        trackOn_q <= 1'b0; // R6
        nullOn_q <= 1'b0; // R7
      end else if (go && cmd == cal_gate_pkg::CMD_TRACK) begin
        trackOn_q <= hwdata[4];
      end else if (go && cmd == cal_gate_pkg::CMD_NULL) begin
        nullOn_q <= hwdata[4];
      end
      if (wrArg) arg_q <= hwdata[19:0];
      if (wrSel && !selLocked) begin // R9
        func_q <= hwdata[cal_gate_pkg::FUNC_W-1:0];
        range_q <= hwdata[8 +: cal_gate_pkg::RANGE_W];
      end
      if (doPoint) isHi_q <= cmd == cal_gate_pkg::CMD_HI_POINT;
      if (doPoint || doStore || doLeave) good_q <= 1'b0;
      if (mode_q == ST_BUSY && engineDone) begin
        if (storeBusy_q) good_q <= engineOk; // R13
        else if (isHi_q) hiCnt_q <= measCount;
        else loCnt_q <= measCount;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) storeBusy_q <= 1'b0;
    else if (doStore) storeBusy_q <= 1'b1;
    else if (doPoint) storeBusy_q <= 1'b0;
  end

  // Pulses to the engine, registered
  logic sample_q, point_q, store_q, flush_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_q <= 1'b0;
      point_q <= 1'b0;
      store_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      sample_q <= go && cmd == cal_gate_pkg::CMD_SAMPLE; // R5
      point_q <= doPoint;
      store_q <= doStore;
      flush_q <= doEnter; // R7
    end
  end

  // Indicator: steady in calibration, blinking on jack alone
  logic lamp_q;
  always_ff @(posedge clk) begin
    if (reset) lamp_q <= 1'b0;
    else lamp_q <= inCal ? 1'b1 : (jackFit & blinkPhase); // R3 R4
  end

  assign sampleTrig = sample_q;
  assign pointStart = point_q;
  assign pointIsHi = isHi_q;
  assign pointArg = arg_q;
  assign storeStart = store_q;
  assign trackOn = trackOn_q;
  assign nullOn = nullOn_q;
  assign nullFlush = flush_q;
  assign funcSel = func_q;
  assign rangeSel = range_q;
  assign calLamp = lamp_q;
  assign calWord = inCal; // R4
  assign goodWord = good_q;
  assign busAddr = addrSw; // R11
  assign irq = |(irqStat_q & irqMask_q);

  // Read mux
  logic [31:0] rdMux;
  always_comb begin
    unique case (ofs_q)
      cal_gate_pkg::OFS_CTRL: rdMux = 32'h0;
      cal_gate_pkg::OFS_STATUS:
        rdMux = {16'h0, err_q, 1'b0, addrOk, good_q, nullOn_q, trackOn_q,
                 jackFit, mode_q == ST_BUSY, inCal, busAddr[3:0]};
      cal_gate_pkg::OFS_IRQ_STAT: rdMux = {28'h0, irqStat_q};
      cal_gate_pkg::OFS_IRQ_MASK: rdMux = {28'h0, irqMask_q};
      cal_gate_pkg::OFS_ARG: rdMux = {12'h0, arg_q};
      cal_gate_pkg::OFS_HI: rdMux = {12'h0, hiCnt_q};
      cal_gate_pkg::OFS_LO: rdMux = {12'h0, loCnt_q};
      cal_gate_pkg::OFS_SEL:
        rdMux = {21'h0, range_q, 5'h0, func_q};
      default: rdMux = 32'h0;
    endcase
  end
  assign hrdata = rdPend_q ? rdMux : 32'h0;

  // Checks
  a_enter_mode: assert property (@(posedge clk) disable iff (reset)
    doEnter |=> mode_q == ST_CAL && calWord) // R1
    else $error("enter command did not select calibration");
  a_jack_reject: assert property (@(posedge clk) disable iff (reset)
    wrCmd && isCalCmd && !jackFit |=> err_q == cal_gate_pkg::ERR_NO_JACK
      && $stable(mode_q)) // R2
    else $error("calibration without jack not rejected");
  a_lamp_steady: assert property (@(posedge clk) disable iff (reset)
    inCal ##1 inCal |-> calLamp) // R4
    else $error("lamp not steady in calibration");
  a_lamp_blink: assert property (@(posedge clk) disable iff (reset)
    !inCal && !jackFit |=> !calLamp) // R3
    else $error("lamp lit without jack");
  a_refuse_normal: assert property (@(posedge clk) disable iff (reset)
    wrCmd && inCal && isNormCmd |=> !sampleTrig && $stable(trackOn)
      && err_q == cal_gate_pkg::ERR_MODE) // R5 R14
    else $error("normal command not refused in calibration");
  a_track_hold: assert property (@(posedge clk) disable iff (reset)
    doEnter |=> !trackOn && !nullOn ##1 nullFlush == 1'b0) // R6 R7
    else $error("entry did not force hold and null clear");
  a_flush_pulse: assert property (@(posedge clk) disable iff (reset)
    doEnter |=> nullFlush) // R7
    else $error("nulls not flushed on entry");
  a_cal_only: assert property (@(posedge clk) disable iff (reset)
    pointStart || storeStart |-> $past(mode_q) == ST_CAL) // R8
    else $error("calibration command outside calibration");
  a_leave_mode: assert property (@(posedge clk) disable iff (reset)
    doLeave |=> mode_q == ST_NORMAL && !calWord) // R10
    else $error("return command did not leave calibration");
endmodule : cal_gate

/* File: verification/cal_engine_model.sv */
// Behavioural measurement engine answering point and store requests
module cal_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Requests
  input wire logic pointStart,
  input wire logic [19:0] pointArg,
  input wire logic storeStart,
  // Bench controls
  input wire logic [3:0] lag,
  input wire logic okIn,
  // Answer
  output logic engineDone,
  output logic engineOk,
  output logic [19:0] measCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] lagCnt_q;
  logic [19:0] arg_q;
  always @(posedge clk) begin
    if (reset) begin
      engineDone <= 1'b0;
      lagCnt_q <= 5'h00;
      engineOk <= 1'b0;
      measCount <= 20'h00000;
    end else if (pointStart || storeStart) begin
      // Stale answer lines never hold the last value
      engineDone <= 1'b0;
      engineOk <= ~engineOk;
      measCount <= ~measCount;
      lagCnt_q <= {1'b0, lag} + 5'h01;
      arg_q <= pointArg;
    end else if (lagCnt_q == 5'h01) begin
      engineDone <= 1'b1;
      engineOk <= okIn;
      measCount <= arg_q + 20'h00011;
      lagCnt_q <= 5'h00;
    end else begin
      engineDone <= 1'b0;
      engineOk <= ~engineOk;
      measCount <= ~measCount;
      if (lagCnt_q != 5'h00) lagCnt_q <= lagCnt_q - 5'h01;
    end
  end
endmodule : cal_engine_model

/* File: verification/calibration_mode_command_gate_bench.sv */
// Self-checking bench for the calibration mode command gate
module calibration_mode_command_gate_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, hsel, hwrite, hreadyout, hresp, jackPin;
  logic talkOnlyPin, listenOnlyPin, sampleTrig, pointStart, pointIsHi;
  logic storeStart, engineDone, engineOk, trackOn, nullOn, nullFlush;
  logic calLamp, calWord, goodWord, irq, okIn;
  logic [31:0] haddr, hwdata, hrdata, rdv, lfsr;
  logic [1:0] htrans;
  logic [2:0] hsize, funcSel, rangeSel;
  logic [4:0] addrSwPin, busAddr;
  logic [19:0] pointArg, measCount, arg;
  logic [3:0] lag;
  logic [3:0] codes [3];
  int err_total, n_tests, n, nSample, nPoint, nStore, nFlush;
  cal_gate #(.BLINK_HALF(4)) DUT (.clk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .jackPin, .addrSwPin, .talkOnlyPin, .listenOnlyPin,
    .sampleTrig, .pointStart, .pointIsHi, .pointArg, .storeStart,
    .engineDone, .engineOk, .measCount, .trackOn, .nullOn, .nullFlush,
    .funcSel, .rangeSel, .calLamp, .calWord, .goodWord, .busAddr, .irq);
  cal_engine_model engine (.clk, .reset, .pointStart, .pointArg,
    .storeStart, .lag, .okIn, .engineDone, .engineOk, .measCount);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    nSample <= nSample + (sampleTrig === 1'b1);
    nPoint <= nPoint + (pointStart === 1'b1);
    nStore <= nStore + (storeStart === 1'b1);
    nFlush <= nFlush + (nullFlush === 1'b1);
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  // Engine answers with the argument plus a fixed offset
  function automatic logic [19:0] expCount(input logic [19:0] a);
    return a + 20'h00011;
  endfunction : expCount
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask : idle
  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2; hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    // Taken at the data phase edge, before it updates
    rdv = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic cmd(input logic [3:0] c, input logic on);
    wr(cal_gate_pkg::OFS_CMD, {27'h0, on, c});
    idle(3);
  endtask : cmd
  task automatic errIs(input logic [3:0] e, input string m);
    bus(cal_gate_pkg::OFS_STATUS, 1'b0, 32'h0);
    chk(rdv[15:12], e, m);
  endtask : errIs
  task automatic settle;
    for (int i = 0; i < 40; i++) begin
      bus(cal_gate_pkg::OFS_STATUS, 1'b0, 32'h0);
      if (rdv[5] === 1'b0) break;
    end
  endtask : settle
  task automatic pins(input logic j, input logic [4:0] a, input logic t, l);
    @(posedge clk);
    jackPin <= j; addrSwPin <= a; talkOnlyPin <= t; listenOnlyPin <= l;
    idle(4);
  endtask : pins
  task automatic lampOnes;
    n = 0;
    repeat (16) begin
      @(negedge clk);
      n += (calLamp === 1'b1);
    end
  endtask : lampOnes
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize;
  end
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {jackPin, talkOnlyPin, listenOnlyPin, okIn} = 4'h1;
    addrSwPin = 5'h03; lag = 4'h2; lfsr = 32'hf; reset = 1'b1;
    {nSample, nPoint, nStore, nFlush} = '0;
    codes = '{cal_gate_pkg::CMD_SAMPLE, cal_gate_pkg::CMD_TRACK,
      cal_gate_pkg::CMD_NULL};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    idle(3);
    bus(cal_gate_pkg::OFS_STATUS, 1'b0, 32'h0);
    chk(rdv[15:0], 16'h0483, "status after reset");
    chk(busAddr, 5'h03, "bus address");
    chk({hresp, hreadyout}, 2'h1, "okay response");
    bus(32'h40, 1'b0, 32'h0);
    chk(rdv, 32'h0, "unmapped read");
    $display("end: reset");
    // Missing jack, interrupt masked then raised
    wr(cal_gate_pkg::OFS_IRQ_MASK, 32'h0);
    cmd(cal_gate_pkg::CMD_ENTER_CAL, 1'b0);
    errIs(cal_gate_pkg::ERR_NO_JACK, "no jack");
    chk(rdv[4], 1'b0, "stays normal");
    chk({irq, calLamp}, 2'h0, "irq masked, lamp dark");
    wr(cal_gate_pkg::OFS_IRQ_MASK, 32'h7);
    idle(2);
    chk(irq, 1'b1, "irq raised");
    bus(cal_gate_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
    chk(rdv, 32'h2, "irq status");
    idle(2);
    chk(irq, 1'b0, "irq cleared");
    $display("end: jack");
    for (int i = 0; i < 3; i++) begin
      pins(1'b1, i == 0 ? 5'h1f : 5'h03, i == 1, i == 2);
      chk(busAddr, i == 0 ? 5'h1f : 5'h03, "switches");
      cmd(cal_gate_pkg::CMD_ENTER_CAL, 1'b0);
      errIs(cal_gate_pkg::ERR_ADDR, "address refused");
    end
    lfsr = nxt(lfsr);
    pins(1'b1, 5'(lfsr % 31), 1'b0, 1'b0);
    lampOnes;
    chk(n > 0 && n < 16, 1, "blink");
    cmd(cal_gate_pkg::CMD_NULL, 1'b1);
    cmd(cal_gate_pkg::CMD_SAMPLE, 1'b0);
    chk({trackOn, nullOn, 30'(nSample)}, {2'h3, 30'h1}, "normal cmds");
    cmd(cal_gate_pkg::CMD_HI_POINT, 1'b0);
    errIs(cal_gate_pkg::ERR_MODE, "hi outside cal");
    cmd(cal_gate_pkg::CMD_ENTER_CAL, 1'b0);
    bus(cal_gate_pkg::OFS_STATUS, 1'b0, 32'h0);
    chk(rdv[4], 1'b1, "entered");
    chk(calWord, 1'b1, "cal word");
    chk(trackOn, 1'b0, "track held");
    chk({nullOn, 31'(nFlush)}, 32'h1, "null cleared");
    lampOnes;
    chk(n, 16, "lamp steady");
    $display("end: entry");
    foreach (codes[i]) begin
      cmd(codes[i], 1'b1);
      errIs(cal_gate_pkg::ERR_MODE, "refused in cal");
    end
    chk({trackOn, nullOn, 30'(nSample)}, 32'h1, "settings kept");
    wr(cal_gate_pkg::OFS_SEL, 32'h0502);
    idle(2);
    chk({funcSel, rangeSel}, 6'h15, "selection");
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      arg = i == 0 ? 20'd999999 : i == 1 ? 20'd0 : 20'(lfsr % 1000000);
      lag <= lfsr[23:20];
      wr(cal_gate_pkg::OFS_ARG, 32'(arg));
      cmd(i[0] ? cal_gate_pkg::CMD_LO_POINT : cal_gate_pkg::CMD_HI_POINT, 0);
      chk({pointIsHi, pointArg}, {~i[0], arg}, "point request");
      settle;
      bus(i[0] ? cal_gate_pkg::OFS_LO : cal_gate_pkg::OFS_HI, 1'b0, 32'h0);
      chk(rdv[19:0], expCount(arg), "point count");
      chk(nPoint, i + 1, "point pulses");
    end
    wr(cal_gate_pkg::OFS_ARG, 32'd1000000);
    cmd(cal_gate_pkg::CMD_HI_POINT, 1'b0);
    errIs(cal_gate_pkg::ERR_ARG, "argument too big");
    lag <= 4'hf;
    wr(cal_gate_pkg::OFS_ARG, 32'd7);
    cmd(cal_gate_pkg::CMD_HI_POINT, 1'b0);
    cmd(cal_gate_pkg::CMD_LO_POINT, 1'b0);
    errIs(cal_gate_pkg::ERR_MODE, "busy refusal");
    chk(nPoint, 5, "one start only");
    settle;
    $display("end: points");
    cmd(cal_gate_pkg::CMD_STORE, 1'b0);
    settle;
    chk({goodWord, 31'(nStore)}, 32'h80000001, "store good");
    okIn <= 1'b0;
    cmd(cal_gate_pkg::CMD_STORE, 1'b0);
    settle;
    errIs(cal_gate_pkg::ERR_STORE, "store fail");
    okIn <= 1'b1;
    cmd(cal_gate_pkg::CMD_LEAVE_CAL, 1'b0);
    bus(cal_gate_pkg::OFS_STATUS, 1'b0, 32'h0);
    chk({rdv[4], calWord}, 2'h0, "left cal");
    lampOnes;
    chk(n > 0 && n < 16, 1, "blink again");
    cmd(cal_gate_pkg::CMD_STORE, 1'b0);
    errIs(cal_gate_pkg::ERR_MODE, "store outside cal");
    pins(1'b0, 5'h03, 1'b0, 1'b0);
    lampOnes;
    chk(n, 0, "lamp dark");
    $display("end: exit");
    summarize;
  end
endmodule : calibration_mode_command_gate_bench
